// ==== src/rst_seq_pkg.sv ====
package rst_seq_pkg;

    // Clock and time-outs
    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned CLK_PER_MS       = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US       = CLK_HZ / 1_000_000;
    localparam int unsigned PWRUP_DELAY_MS   = 72;
    localparam int unsigned PWRUP_DELAY_CYC  = PWRUP_DELAY_MS * CLK_PER_MS;
    localparam int unsigned BOR_MIN_US       = 100;
    localparam int unsigned BOR_MIN_CYC      = BOR_MIN_US * CLK_PER_US;
    localparam int unsigned OSC_SETTLE_EDGES = 1024;

    // APB register map
    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned DATA_W           = 32;
    localparam logic [7:0]  OFS_POWER_STATUS = 8'h00;
    localparam logic [7:0]  OFS_CONFIG       = 8'h04;
    localparam logic [7:0]  OFS_SEQ_STATUS   = 8'h08;

    // power_status_reg fields
    localparam int unsigned PS_BROWNOUT_BIT  = 0;
    localparam int unsigned PS_POWERON_BIT   = 1;
    localparam logic [1:0]  PS_RESET         = 2'h0;

    // Configuration register fields
    localparam int unsigned CFG_W            = 5;
    localparam int unsigned CFG_BOR_EN_BIT   = 0;
    localparam int unsigned CFG_LEVEL_BIT    = 1;
    localparam int unsigned CFG_PWRUP_N_BIT  = 2;
    localparam int unsigned CFG_OSC_LSB      = 3;
    localparam logic [4:0]  CFG_RESET        = 5'h1B;

    // Sequencer status fields
    localparam int unsigned SS_TIMEOUT_BIT   = 0;
    localparam int unsigned SS_PWRDOWN_BIT   = 1;
    localparam int unsigned SS_RESET_BIT     = 2;
    localparam int unsigned SS_HOLD_BIT      = 3;
    localparam int unsigned SS_BROWNOUT_BIT  = 4;

    // Restart addresses
    localparam int unsigned PC_W             = 13;
    localparam logic [12:0] RESET_VECTOR     = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR       = 13'h0004;
    localparam logic [12:0] PC_STEP          = 13'h0001;

    typedef enum logic [1:0] {
        lowpower_crystal_mode       = 2'h0,
        crystal_mode                = 2'h1,
        highspeed_crystal_mode      = 2'h2,
        resistor_capacitor_osc_mode = 2'h3
    } osc_mode_t;

endpackage

// ==== src/delay_counter.sv ====
`timescale 1ns/1ps
module delay_counter
    import rst_seq_pkg::*;
#(
    parameter int unsigned COUNT = 1024
) (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic run_i,
    input  wire logic tick_i,
    output logic      done_o
);

    localparam int unsigned W = $clog2(COUNT + 1);

    if (COUNT < 1) begin : g_chk
        $error("delay_counter: COUNT must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } cnt_state_t;

    cnt_state_t cur;
    cnt_state_t next_cur;

    // Count ticks while running; dropping run restarts from zero
    always_comb begin
        next_cur = cur;
        if (!run_i) begin
            next_cur.cnt  = '0;
            next_cur.done = 1'b0;
        end else if (tick_i && !cur.done) begin
            next_cur.cnt  = cur.cnt + 1'b1;
            next_cur.done = (next_cur.cnt == W'(COUNT));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign done_o = cur.done;

endmodule

// ==== src/brownout_filter.sv ====
`timescale 1ns/1ps
module brownout_filter
    import rst_seq_pkg::*;
#(
    parameter int unsigned MIN_CYC = BOR_MIN_CYC
) (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic enable_i,
    input  wire logic below_i,
    output logic      trip_o
);

    localparam int unsigned W = $clog2(MIN_CYC + 1);

    if (MIN_CYC < 1) begin : g_chk
        $error("brownout_filter: MIN_CYC must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         trip;
    } filt_state_t;

    filt_state_t cur;
    filt_state_t next_cur;

    // Trip only after the dip outlasts the minimum; release on recovery
    always_comb begin
        next_cur = cur;
        if (!enable_i || !below_i) begin
            next_cur.cnt  = '0;
            next_cur.trip = 1'b0;
        end else if (cur.cnt == W'(MIN_CYC)) begin
            next_cur.trip = 1'b1;
        end else begin
            next_cur.cnt = cur.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign trip_o = cur.trip;

endmodule

// ==== src/reset_timeout_sequencer.sv ====
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module reset_timeout_sequencer
    import rst_seq_pkg::*;
#(
    parameter int unsigned PWRUP_CYC    = PWRUP_DELAY_CYC,
    parameter int unsigned BOR_CYC      = BOR_MIN_CYC,
    parameter int unsigned SETTLE_EDGES = OSC_SETTLE_EDGES
) (
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              por_i,
    input  wire logic              below_4v0_i,
    input  wire logic              below_2v5_i,
    input  wire logic              master_clear_n_i,
    input  wire logic              osc_clk_i,
    input  wire logic              watchdog_reset_i,
    input  wire logic              watchdog_wake_i,
    input  wire logic              irq_wake_i,
    input  wire logic              sleeping_i,
    input  wire logic              global_irq_enable_i,
    input  wire logic [PC_W-1:0]   pc_i,
    output logic                   core_reset_o,
    output logic                   core_hold_o,
    output logic                   restart_load_o,
    output logic      [PC_W-1:0]   restart_addr_o,
    output logic                   timeout_flag_n_o,
    output logic                   powerdown_flag_n_o
);

    if (PWRUP_CYC < 1 || BOR_CYC < 1 || SETTLE_EDGES < 1) begin : g_chk
        $error("reset_timeout_sequencer: counts must be at least 1");
    end

    typedef enum logic [1:0] {
        ST_SUPPLY,
        ST_PWRUP,
        ST_SETTLE,
        ST_RUN
    } seq_state_t;

    typedef struct packed {
        seq_state_t        st;
        logic              por_cause;
        logic              wake;
        logic              wake_vec;
        logic              master_clear_n_q;
        logic              osc_q;
        logic [1:0]        pstat;
        logic [CFG_W-1:0]  cfg;
        logic              timeout_flag_n;
        logic              powerdown_flag_n;
        logic              core_reset;
        logic              core_hold;
        logic              restart_load;
        logic [PC_W-1:0]   restart_addr;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } seq_regs_t;

    localparam seq_regs_t REGS_RESET = '{
        st:               ST_SUPPLY,
        por_cause:        1'b1,
        wake:             1'b0,
        wake_vec:         1'b0,
        master_clear_n_q:           1'b1,
        osc_q:            1'b0,
        pstat:            PS_RESET,
        cfg:              CFG_RESET,
        timeout_flag_n:   1'b1,
        powerdown_flag_n: 1'b1,
        core_reset:       1'b1,
        core_hold:        1'b1,
        restart_load:     1'b0,
        restart_addr:     RESET_VECTOR,
        prdata:           '0,
        pready:           1'b0,
        pslverr:          1'b0
    };

    seq_regs_t cur;
    seq_regs_t next_cur;

    logic      bor_en;
    logic      below;
    logic      crystal;
    logic      bor_trip;
    logic      pwrup_done;
    logic      settle_done;
    logic      osc_edge;

    assign bor_en   = cur.cfg[CFG_BOR_EN_BIT];
    assign below    = cur.cfg[CFG_LEVEL_BIT] ? below_4v0_i : below_2v5_i;
    assign crystal  = osc_mode_t'(cur.cfg[CFG_OSC_LSB +: 2]) != resistor_capacitor_osc_mode;
    assign osc_edge = osc_clk_i && !cur.osc_q;

    brownout_filter #(
        .MIN_CYC (BOR_CYC)
    ) u_bor_filter (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .enable_i  (bor_en),
        .below_i   (below),
        .trip_o    (bor_trip)
    );

    // Power-up delay timer, restarted whenever its state is left
    delay_counter #(
        .COUNT (PWRUP_CYC)
    ) u_power_up_delay_timer (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .run_i     (cur.st == ST_PWRUP),
        .tick_i    (1'b1),
        .done_o    (pwrup_done)
    );

    delay_counter #(
        .COUNT (SETTLE_EDGES)
    ) u_oscillator_settle_timer (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .run_i     (cur.st == ST_SETTLE),
        .tick_i    (osc_edge),
        .done_o    (settle_done)
    );

    always_comb begin
        next_cur              = cur;
        next_cur.master_clear_n_q       = master_clear_n_i;
        next_cur.osc_q        = osc_clk_i;
        next_cur.restart_load = 1'b0;
        next_cur.pready       = 1'b0;
        next_cur.pslverr      = 1'b0;

        // APB setup: decode and prepare the answer for the access phase
        if (psel_i && !penable_i) begin
            next_cur.pready = 1'b1;
            next_cur.prdata = '0;
            case (paddr_i)
                OFS_POWER_STATUS: begin
                    next_cur.prdata[1:0] = cur.pstat;
                end
                OFS_CONFIG: begin
                    next_cur.prdata[CFG_W-1:0] = cur.cfg;
                end
                OFS_SEQ_STATUS: begin
                    next_cur.prdata[SS_TIMEOUT_BIT]  = cur.timeout_flag_n;
                    next_cur.prdata[SS_PWRDOWN_BIT]  = cur.powerdown_flag_n;
                    next_cur.prdata[SS_RESET_BIT]    = cur.core_reset;
                    next_cur.prdata[SS_HOLD_BIT]     = cur.core_hold;
                    next_cur.prdata[SS_BROWNOUT_BIT] = bor_trip;
                end
                default: begin
                    next_cur.pslverr = 1'b1;
                end
            endcase
        end

        // APB access: write takes effect on the completing edge
        if (psel_i && penable_i && cur.pready && pwrite_i && !cur.pslverr) begin
            case (paddr_i)
                OFS_POWER_STATUS: begin
                    next_cur.pstat = pwdata_i[1:0];
                end
                OFS_CONFIG: begin
                    next_cur.cfg = pwdata_i[CFG_W-1:0];
                end
                default: begin
                    next_cur.cfg = cur.cfg;
                end
            endcase
        end

        // Hardware events are applied last so they win over a software write
        if (por_i) begin
            next_cur.st                    = ST_SUPPLY;
            next_cur.por_cause             = 1'b1;
            next_cur.wake                  = 1'b0;
            next_cur.pstat[PS_POWERON_BIT] = 1'b0;
            if (bor_en) begin
                next_cur.pstat[PS_BROWNOUT_BIT] = 1'b1;
            end
            // Brown-out status left as it was when detection is off
            next_cur.timeout_flag_n   = 1'b1;
            next_cur.powerdown_flag_n = 1'b1;
        end else if (bor_trip) begin
            next_cur.st                     = ST_SUPPLY;
            next_cur.wake                   = 1'b0;
            next_cur.pstat[PS_BROWNOUT_BIT] = 1'b0;
            next_cur.timeout_flag_n         = 1'b1;
            next_cur.powerdown_flag_n       = 1'b1;
        end else begin
            case (cur.st)
                ST_SUPPLY: begin
                    if (!(bor_en && below)) begin
                        if (!cur.cfg[CFG_PWRUP_N_BIT]) begin
                            next_cur.st = ST_PWRUP;
                        end else if (crystal && cur.por_cause) begin
                            next_cur.st = ST_SETTLE;
                        end else begin
                            next_cur.st = ST_RUN;
                        end
                    end
                end
                ST_PWRUP: begin
                    if (pwrup_done) begin
                        if (crystal && cur.por_cause) begin
                            next_cur.st = ST_SETTLE;
                        end else begin
                            next_cur.st = ST_RUN;
                        end
                    end
                end
                ST_SETTLE: begin
                    if (cur.wake && !master_clear_n_i) begin
                        next_cur.st               = ST_RUN;
                        next_cur.wake             = 1'b0;
                        next_cur.timeout_flag_n   = 1'b1;
                        next_cur.powerdown_flag_n = 1'b0;
                    end else if (settle_done) begin
                        next_cur.st = ST_RUN;
                        if (cur.wake) begin
                            next_cur.wake         = 1'b0;
                            next_cur.restart_load = 1'b1;
                            next_cur.restart_addr = cur.wake_vec ? IRQ_VECTOR
                                                                 : pc_i + PC_STEP;
                        end
                    end
                end
                ST_RUN: begin
                    next_cur.por_cause = 1'b0;
                    if (sleeping_i && (watchdog_wake_i || irq_wake_i)) begin
                        next_cur.timeout_flag_n   = !watchdog_wake_i;
                        next_cur.powerdown_flag_n = 1'b0;
                        next_cur.wake_vec = !watchdog_wake_i && global_irq_enable_i;
                        if (crystal) begin
                            next_cur.st   = ST_SETTLE;
                            next_cur.wake = 1'b1;
                        end else begin
                            next_cur.restart_load = 1'b1;
                            next_cur.restart_addr = next_cur.wake_vec ? IRQ_VECTOR
                                                                      : pc_i + PC_STEP;
                        end
                    end else if (watchdog_reset_i && !sleeping_i) begin
                        next_cur.timeout_flag_n   = 1'b0;
                        next_cur.powerdown_flag_n = 1'b1;
                    end else if (cur.master_clear_n_q && !master_clear_n_i && sleeping_i) begin
                        next_cur.timeout_flag_n   = 1'b1;
                        next_cur.powerdown_flag_n = 1'b0;
                    end
                    // Master clear while awake leaves both flags as they are
                end
                default: begin
                    next_cur.st = ST_SUPPLY;
                end
            endcase
        end

        // One internal reset; watchdog reset drives core_reset_o like the other sources
        next_cur.core_reset = por_i || bor_trip || !master_clear_n_i || watchdog_reset_i
                              || (next_cur.st != ST_RUN && !next_cur.wake);
        next_cur.core_hold  = next_cur.core_reset || next_cur.wake;

        // Leaving a true reset always restarts at the reset vector
        if (cur.core_reset && !next_cur.core_reset) begin
            next_cur.restart_load = 1'b1;
            next_cur.restart_addr = RESET_VECTOR;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cur <= REGS_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata_o           = cur.prdata;
    assign pready_o           = cur.pready;
    assign pslverr_o          = cur.pslverr;
    assign core_reset_o       = cur.core_reset;
    assign core_hold_o        = cur.core_hold;
    assign restart_load_o     = cur.restart_load;
    assign restart_addr_o     = cur.restart_addr;
    assign timeout_flag_n_o   = cur.timeout_flag_n;
    assign powerdown_flag_n_o = cur.powerdown_flag_n;

endmodule

// ==== bench/rst_seq_checker.sv ====
`timescale 1ns/1ps
module rst_seq_checker
    import rst_seq_pkg::*;
#(
    parameter int unsigned PWRUP_CYC    = PWRUP_DELAY_CYC,
    parameter int unsigned BOR_CYC      = BOR_MIN_CYC,
    parameter int unsigned SETTLE_EDGES = OSC_SETTLE_EDGES
) (
    input wire logic            clk_sys_i,
    input wire logic            nrst_i,
    input wire logic            psel_i,
    input wire logic            penable_i,
    input wire logic            por_i,
    input wire logic            master_clear_n_i,
    input wire logic            watchdog_reset_i,
    input wire logic            sleeping_i,
    input wire logic            pready_o,
    input wire logic            pslverr_o,
    input wire logic            core_reset_o,
    input wire logic            restart_load_o,
    input wire logic [PC_W-1:0] restart_addr_o,
    input wire logic            timeout_flag_n_o,
    input wire logic            powerdown_flag_n_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup cycle");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_paired: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_por_holds: assert property (por_i
        |=> core_reset_o && timeout_flag_n_o && powerdown_flag_n_o)
        else $error("power-on did not hold reset and set flags");
    a_wdog_holds: assert property (watchdog_reset_i |=> core_reset_o)
        else $error("watchdog request did not hold reset");
    a_master_clear_n_holds: assert property (!master_clear_n_i |-> ##[1:2] core_reset_o)
        else $error("master clear did not hold reset");
    a_release_gate: assert property ($fell(core_reset_o)
        |-> $past(master_clear_n_i) && !$past(watchdog_reset_i))
        else $error("reset released while a request was active");
    a_reset_vector: assert property ($fell(core_reset_o)
        |-> restart_load_o && restart_addr_o == RESET_VECTOR)
        else $error("reset release without load of zero vector");
    a_load_pulse: assert property (restart_load_o |=> !restart_load_o)
        else $error("restart load longer than one cycle");
    a_wdog_flags: assert property (watchdog_reset_i && !sleeping_i && !core_reset_o && !por_i
        |=> !timeout_flag_n_o && powerdown_flag_n_o)
        else $error("watchdog reset flags wrong");
endmodule

bind reset_timeout_sequencer rst_seq_checker #(.PWRUP_CYC(PWRUP_CYC), .BOR_CYC(BOR_CYC),
    .SETTLE_EDGES(SETTLE_EDGES)) checker_i (.clk_sys_i, .nrst_i, .psel_i, .penable_i, .por_i,
    .master_clear_n_i, .watchdog_reset_i, .sleeping_i, .pready_o, .pslverr_o, .core_reset_o,
    .restart_load_o, .restart_addr_o, .timeout_flag_n_o, .powerdown_flag_n_o);

// ==== bench/supply_monitor_model.sv ====
`timescale 1ns/1ps
module supply_monitor_model (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] vdd_mv_i,
    input  wire logic        master_clear_n_press_i,
    output logic             por_o,
    output logic             below_4v0_o,
    output logic             below_2v5_o,
    output logic             master_clear_n_o,
    output logic             osc_clk_o
);
    logic [1:0] osc_div = 2'h0;

    // Crystal runs at a quarter of the system clock
    always @(posedge clk_sys_i) begin
        osc_div <= osc_div + 2'h1;
    end
    assign osc_clk_o        = osc_div[1];
    assign por_o            = vdd_mv_i < 16'h05DC;
    assign below_4v0_o      = vdd_mv_i < 16'h0FA0;
    assign below_2v5_o      = vdd_mv_i < 16'h09C4;
    // Pin pulled up unless pressed
    assign master_clear_n_o = !master_clear_n_press_i;
endmodule

// ==== bench/reset_timeout_sequencer_bench.sv ====
`timescale 1ns/1ps
module reset_timeout_sequencer_bench;
    import rst_seq_pkg::*;
    localparam int PW = 20;
    localparam int BC = 4;
    localparam int SE = 8;
    localparam logic [15:0] V_OK  = 16'h1388;
    localparam logic [15:0] V_MID = 16'h0BB8;
    localparam logic [15:0] V_LOW = 16'h07D0;
    logic        clk_sys_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, watchdog_reset_i = 1'b0, watchdog_wake_i = 1'b0;
    logic        irq_wake_i = 1'b0, sleeping_i = 1'b0, global_irq_enable_i = 1'b0;
    logic        master_clear_n_press = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd_data;
    logic [12:0] pc_i = 13'h0123, restart_addr_o;
    logic [15:0] vdd_mv = V_OK;
    logic        pready_o, pslverr_o, por_i, below_4v0_i, below_2v5_i, master_clear_n_i;
    logic        osc_clk_i, core_reset_o, core_hold_o, restart_load_o, rd_err;
    logic        timeout_flag_n_o, powerdown_flag_n_o;
    logic [2:0]  wk_kind [6] = '{3'h0, 3'h1, 3'h0, 3'h3, 3'h0, 3'h2};
    logic [12:0] wk_addr [6] = '{13'h0124, 13'h0124, 13'h0124, 13'h0000, 13'h0124, 13'h0004};
    logic [1:0]  wk_flag [6] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2};
    int          bad_count = 0;
    int          tests_run = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    reset_timeout_sequencer #(.PWRUP_CYC(PW), .BOR_CYC(BC), .SETTLE_EDGES(SE)) DUT (
        .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .por_i, .below_4v0_i, .below_2v5_i, .master_clear_n_i,
        .osc_clk_i, .watchdog_reset_i, .watchdog_wake_i, .irq_wake_i, .sleeping_i,
        .global_irq_enable_i, .pc_i, .core_reset_o, .core_hold_o, .restart_load_o,
        .restart_addr_o, .timeout_flag_n_o, .powerdown_flag_n_o);

    supply_monitor_model PM (.clk_sys_i, .vdd_mv_i(vdd_mv), .master_clear_n_press_i(master_clear_n_press),
        .por_o(por_i), .below_4v0_o(below_4v0_i), .below_2v5_o(below_2v5_i),
        .master_clear_n_o(master_clear_n_i), .osc_clk_o(osc_clk_i));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        tick(1);
        penable_i <= 1'b1;
        do begin
            tick(1);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        rd_data = prdata_o;
        rd_err  = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_data & m, e);
    endtask

    task automatic power_cycle();
        vdd_mv <= 16'h0000;
        tick(3);
        vdd_mv <= V_OK;
    endtask

    // Cycles until reset falls, bounded, compared with a window
    task automatic rel(input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset_o !== 1'b0 && n <= hi) begin
            tick(1);
            n++;
        end
        chk(n >= lo && n <= hi, 1);
        if (n > hi) begin
            print_verdict();
        end
    endtask

    task automatic wait_load();
        int n;
        n = 0;
        while (restart_load_o !== 1'b1 && n < 64) begin
            tick(1);
            n++;
        end
        if (restart_load_o !== 1'b1) begin
            bad_count++;
            print_verdict();
        end
    endtask

    initial begin
        tick(16);
        nrst_i <= 1'b1;
        tick(1);
        rd(OFS_CONFIG, 32'hFFFF_FFFF, 32'h1B);
        power_cycle();
        rel(PW, PW + 8);
        rd(OFS_POWER_STATUS, 32'h3, 32'h1);
        rd(OFS_SEQ_STATUS, 32'h3, 32'h3);
        apb(1'b1, OFS_POWER_STATUS, 32'h3);
        vdd_mv <= V_MID;
        tick(BC + 4);
        chk(core_reset_o, 1);
        rd(OFS_POWER_STATUS, 32'h3, 32'h2);
        rd(OFS_SEQ_STATUS, 32'h3, 32'h3);
        vdd_mv <= V_OK;
        tick(PW / 2);
        vdd_mv <= V_MID;
        tick(BC + 4);
        vdd_mv <= V_OK;
        rel(PW, PW + 8);
        vdd_mv <= V_MID;
        tick(BC - 2);
        vdd_mv <= V_OK;
        tick(4);
        chk(core_reset_o, 0);
        apb(1'b1, OFS_CONFIG, 32'h19);
        vdd_mv <= V_MID;
        tick(BC + 6);
        chk(core_reset_o, 0);
        vdd_mv <= V_LOW;
        tick(BC + 4);
        chk(core_reset_o, 1);
        vdd_mv <= V_OK;
        rel(PW, PW + 8);
        apb(1'b1, OFS_CONFIG, 32'h1E);
        power_cycle();
        rel(0, 5);
        rd(OFS_POWER_STATUS, 32'h2, 32'h0);
        vdd_mv <= V_LOW;
        tick(BC + 6);
        chk(core_reset_o, 0);
        vdd_mv <= V_OK;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_CONFIG, i ? 32'h0B : 32'h0F);
            power_cycle();
            rel(i * PW + 4 * SE - 4, i * PW + 4 * SE + 12);
        end
        master_clear_n_press <= 1'b1;
        power_cycle();
        tick(PW + 4 * SE + 20);
        chk(core_reset_o, 1);
        master_clear_n_press <= 1'b0;
        rel(0, 4);
        master_clear_n_press <= 1'b1;
        tick(2);
        master_clear_n_press <= 1'b0;
        chk({timeout_flag_n_o, powerdown_flag_n_o}, 2'h3);
        rel(0, 5);
        apb(1'b1, OFS_CONFIG, 32'h1F);
        apb(1'b1, OFS_POWER_STATUS, 32'h3);
        watchdog_reset_i <= 1'b1;
        tick(3);
        chk({timeout_flag_n_o, powerdown_flag_n_o}, 2'h1);
        watchdog_reset_i <= 1'b0;
        rel(0, 5);
        rd(OFS_POWER_STATUS, 32'h3, 32'h3);
        for (int k = 0; k < 6; k++) begin
            sleeping_i <= 1'b1;
            global_irq_enable_i <= (wk_kind[k] == 3'h2);
            tick(1);
            watchdog_wake_i <= (wk_kind[k] == 3'h0);
            irq_wake_i <= (wk_kind[k] == 3'h1 || wk_kind[k] == 3'h2);
            master_clear_n_press <= (wk_kind[k] == 3'h3);
            tick(1);
            watchdog_wake_i <= 1'b0;
            irq_wake_i <= 1'b0;
            master_clear_n_press <= 1'b0;
            sleeping_i <= 1'b0;
            wait_load();
            chk(restart_addr_o, wk_addr[k]);
            chk({timeout_flag_n_o, powerdown_flag_n_o}, wk_flag[k]);
        end
        // Crystal wake settles with core held, interrupt enable still set
        apb(1'b1, OFS_CONFIG, 32'h0F);
        sleeping_i <= 1'b1;
        tick(1);
        irq_wake_i <= 1'b1;
        tick(1);
        irq_wake_i <= 1'b0;
        sleeping_i <= 1'b0;
        tick(2);
        chk({core_reset_o, core_hold_o}, 2'h1);
        wait_load();
        chk({core_hold_o, restart_addr_o}, 14'h0004);
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd_err, rd_data[30:0]}, 32'h8000_0000);
        apb(1'b1, OFS_SEQ_STATUS, 32'h0);
        rd(OFS_SEQ_STATUS, 32'h3, 32'h1);
        print_verdict();
    end
endmodule
